// *** hw/qtrbc_bank.sv ***
// Ranging and bias ceiling register bank with bias clamp and signal loss hysteresis.
// Assumes a byte-wide serial-bus register port already decoded from the two-wire bus,
// a nonvolatile store that loads values after reset, and the analog comparator results.
`timescale 1ns/1ps
`include "qtrbc_cfg.svh"

// Contract
// [R1] Bits 6:4 of signal loss range register set high loss threshold range.
// [R2] Bits 2:0 set low loss range; codes map 100 to 25 percent of 1.25V.
// [R3] Upper field of trip range register sets bias monitor range, same decode.
// [R4] Lower field sets power loop range for quick trip and closed-loop monitoring.
// [R5] Power loop range defaults 000b, 2.50V full scale, same eight fractions.
// [R6] Bias ceiling holds maximum upper eight bits of bias DAC in closed loop.
// [R7] During stepping and search, clamp bias at ceiling but raise no alarm.
// [R8] After startup, bias above ceiling is clamped and sets the maximum-bias alarm.
// [R9] Reads need level two, or level one with table read-write or read permit.
// [R10] Writes need level two, or level one with table read-write permit.
// [R11] Register contents persist through nonvolatile storage across power cycles.
// [R12] Maximum-bias alarm detection is enabled only after the binary search completes.
// [R13] Low loss alarm sets below low threshold; held until above high, then high set.
// [R14] Reserved bits 7 and 3 of ranging registers read zero, ignore writes.
module qtrbc_bank (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Access rights
    input wire logic password_level_one,
    input wire logic password_level_two,
    input wire logic table_rw_permit,
    input wire logic table_read_permit,
    // Nonvolatile store
    input wire logic nv_load,
    input wire logic [7:0] nv_los_range,
    input wire logic [7:0] nv_trip_range,
    input wire logic [7:0] nv_bias_ceiling,
    output logic nv_write,
    output logic [7:0] nv_addr,
    output logic [7:0] nv_wdata,
    // Power loop bias path
    input wire logic loop_startup,
    input wire logic search_done,
    input wire logic bias_req_valid,
    input wire logic [7:0] bias_req,
    output logic [7:0] bias_dac,
    output logic bias_max_alarm,
    // Range selections to the analog trip comparators
    output logic [2:0] signal_loss_high_range,
    output logic [2:0] signal_loss_low_range,
    output logic [2:0] bias_trip_range,
    output logic [2:0] power_loop_range,
    // Signal loss comparator inputs, asynchronous to clk_sys
    input wire logic rx_below_low,
    input wire logic rx_above_high,
    output logic los_low_alarm,
    output logic los_high_alarm
);

    // ======================================================================
    // Reset release
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ======================================================================
    // Access decode
    function automatic logic hit(input logic [7:0] a);
        hit = (a == `QTRBC_ADDR_LOS_RANGE) || (a == `QTRBC_ADDR_TRIP_RANGE) ||
              (a == `QTRBC_ADDR_BIAS_CEIL);
    endfunction : hit

    wire rd_ok = password_level_two ||
                 (password_level_one && (table_rw_permit || table_read_permit)); // [R9]
    wire wr_ok = password_level_two || (password_level_one && table_rw_permit); // [R10]
    wire wr_go = reg_wr && wr_ok && hit(reg_addr);
    wire wr_los = wr_go && (reg_addr == `QTRBC_ADDR_LOS_RANGE);
    wire wr_trip = wr_go && (reg_addr == `QTRBC_ADDR_TRIP_RANGE);
    wire wr_ceil = wr_go && (reg_addr == `QTRBC_ADDR_BIAS_CEIL);
    wire [7:0] wr_val = (reg_addr == `QTRBC_ADDR_BIAS_CEIL) ? reg_wdata
                        : (reg_wdata & `QTRBC_RANGE_MASK); // [R14]

    // ======================================================================
    // Registers
    logic [7:0] los_threshold_range_q;
    logic [7:0] trip_range_bias_loop_q;
    logic [7:0] bias_dac_ceiling_q;

    // Stored values come back from the nonvolatile store after power-up.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            los_threshold_range_q <= `QTRBC_RST_LOS_RANGE;
            trip_range_bias_loop_q <= `QTRBC_RST_TRIP_RANGE; // [R5]
            bias_dac_ceiling_q <= `QTRBC_RST_BIAS_CEIL;
        end else if (nv_load) begin
            los_threshold_range_q <= nv_los_range & `QTRBC_RANGE_MASK; // [R11]
            trip_range_bias_loop_q <= nv_trip_range & `QTRBC_RANGE_MASK;
            bias_dac_ceiling_q <= nv_bias_ceiling;
        end else begin
            if (wr_los) los_threshold_range_q <= wr_val;
            if (wr_trip) trip_range_bias_loop_q <= wr_val;
            if (wr_ceil) bias_dac_ceiling_q <= wr_val; // [R6]
        end
    end

    // Each accepted write is mirrored to the nonvolatile store.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nv_write <= 1'b0;
            nv_addr <= 8'h00;
            nv_wdata <= 8'h00;
        end else begin
            nv_write <= wr_go && !nv_load; // [R11]
            nv_addr <= reg_addr;
            nv_wdata <= wr_val;
        end
    end

    // ======================================================================
    // Read path; refused reads return zero with a valid strobe.
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            `QTRBC_ADDR_LOS_RANGE: rd_mux = los_threshold_range_q;
            `QTRBC_ADDR_TRIP_RANGE: rd_mux = trip_range_bias_loop_q;
            `QTRBC_ADDR_BIAS_CEIL: rd_mux = bias_dac_ceiling_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_rdata <= (reg_rd && rd_ok) ? rd_mux : 8'h00; // [R9]
        end
    end

    // ======================================================================
    // Range outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            signal_loss_high_range <= 3'h0;
            signal_loss_low_range <= 3'h0;
            bias_trip_range <= 3'h0;
            power_loop_range <= 3'h0;
        end else begin
            signal_loss_high_range <= los_threshold_range_q[6:4]; // [R1]
            signal_loss_low_range <= los_threshold_range_q[2:0]; // [R2]
            bias_trip_range <= trip_range_bias_loop_q[6:4]; // [R3]
            power_loop_range <= trip_range_bias_loop_q[2:0]; // [R4] [R5]
        end
    end

    // ======================================================================
    // Loop phase and bias clamp
    qtrbc_pkg::qtrbc_loop_t phase_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= qtrbc_pkg::QTRBC_LOOP_IDLE;
        end else if (loop_startup) begin
            phase_q <= qtrbc_pkg::QTRBC_LOOP_STARTUP;
        end else if (phase_q == qtrbc_pkg::QTRBC_LOOP_STARTUP && search_done) begin
            phase_q <= qtrbc_pkg::QTRBC_LOOP_CLOSED; // [R12]
        end
    end

    wire over = bias_req > bias_dac_ceiling_q;
    wire alarm_arm = (phase_q == qtrbc_pkg::QTRBC_LOOP_CLOSED); // [R12]

    // The alarm is sticky until the loop restarts; a new startup clears it unless a closed-loop over-ceiling request sets it in the same cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bias_dac <= 8'h00;
            bias_max_alarm <= 1'b0;
        end else begin
            if (bias_req_valid) bias_dac <= over ? bias_dac_ceiling_q : bias_req; // [R7] [R8]
            if (bias_req_valid && over && alarm_arm) begin
                bias_max_alarm <= 1'b1; // [R8]
            end else if (loop_startup) begin
                bias_max_alarm <= 1'b0; // [R7]
            end
        end
    end

    // ======================================================================
    // Signal loss hysteresis
    logic [2:0] low_sync_q;
    logic [2:0] high_sync_q;
    logic low_st_q;
    logic high_st_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_sync_q <= 3'b000;
            high_sync_q <= 3'b000;
            low_st_q <= 1'b0;
            high_st_q <= 1'b0;
        end else begin
            low_sync_q <= {low_sync_q[1:0], rx_below_low};
            high_sync_q <= {high_sync_q[1:0], rx_above_high};
            if (low_sync_q[2] == low_sync_q[1]) low_st_q <= low_sync_q[2];
            if (high_sync_q[2] == high_sync_q[1]) high_st_q <= high_sync_q[2];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            los_low_alarm <= 1'b0;
            los_high_alarm <= 1'b0;
        end else if (!los_low_alarm && low_st_q) begin
            los_low_alarm <= 1'b1; // [R13]
            los_high_alarm <= 1'b0;
        end else if (los_low_alarm && high_st_q) begin
            los_low_alarm <= 1'b0; // [R13]
            los_high_alarm <= 1'b1;
        end
    end

endmodule : qtrbc_bank

// *** hw/qtrbc_cfg.svh ***
// Register offsets, field positions and reset values for the ranging and bias ceiling bank.
// Assumes inclusion by bare name from the bank module.
`ifndef QTRBC_CFG_SVH
`define QTRBC_CFG_SVH

// ==========================================================================
// Register map
`define QTRBC_ADDR_LOS_RANGE 8'hb8
`define QTRBC_ADDR_TRIP_RANGE 8'hb9
`define QTRBC_ADDR_BIAS_CEIL 8'hba

// ==========================================================================
// Reset values and field layout
`define QTRBC_RST_LOS_RANGE 8'h00
`define QTRBC_RST_TRIP_RANGE 8'h00
`define QTRBC_RST_BIAS_CEIL 8'h00
`define QTRBC_FLD_HI_MSB 6
`define QTRBC_FLD_HI_LSB 4
`define QTRBC_FLD_LO_MSB 2
`define QTRBC_FLD_LO_LSB 0
`define QTRBC_RANGE_MASK 8'h77

// ==========================================================================
// Range percentages in hundredths, code 0 to 7
`define QTRBC_PCT_TABLE {14'd10000, 14'd8000, 14'd6667, 14'd5000, \
                         14'd4000, 14'd3333, 14'd2857, 14'd2500}
`define QTRBC_FS_LOS_MV 16'd1250
`define QTRBC_FS_LOOP_MV 16'd2500

`endif

// *** hw/qtrbc_pkg.sv ***
// Types shared by the ranging and bias ceiling bank.
// Assumes qtrbc_cfg.svh is on the include path.
package qtrbc_pkg;

    typedef logic [2:0] qtrbc_range_t;

    typedef enum logic [1:0] {
        QTRBC_LOOP_IDLE,
        QTRBC_LOOP_STARTUP,
        QTRBC_LOOP_CLOSED
    } qtrbc_loop_t;

endpackage : qtrbc_pkg

// *** bench/qtrbc_bank_properties.sv ***
// Concurrent checks on the ports of the ranging and bias ceiling bank.
// Assumes a bind from the bench top module; port names match the bank's ports.
`timescale 1ns/1ps
module qtrbc_bank_properties (
    // Clock, reset, register port and access rights
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic password_level_one,
    input wire logic password_level_two,
    input wire logic table_rw_permit,
    input wire logic table_read_permit,
    // Store, bias path and ranges
    input wire logic nv_load,
    input wire logic nv_write,
    input wire logic [7:0] nv_addr,
    input wire logic [7:0] nv_wdata,
    input wire logic bias_req_valid,
    input wire logic [7:0] bias_req,
    input wire logic [7:0] bias_dac,
    input wire logic bias_max_alarm,
    input wire logic [2:0] signal_loss_high_range,
    input wire logic [2:0] signal_loss_low_range,
    input wire logic [2:0] bias_trip_range,
    input wire logic [2:0] power_loop_range
);
    // ==========================================================================
    // Properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire wr_ok = password_level_two || (password_level_one && table_rw_permit);
    wire rd_ok = wr_ok || (password_level_one && table_read_permit);
    wire mapped = (reg_addr >= 8'hb8) && (reg_addr <= 8'hba);
    property p_rd_refused; reg_rd && !rd_ok |=> reg_rdata == 8'h00; endproperty
    a_rd_refused: assert property (p_rd_refused) else $error("refused read gave data");
    property p_wr_taken;
        reg_wr && wr_ok && mapped && !nv_load |=> nv_write && nv_addr == $past(reg_addr);
    endproperty
    a_wr_taken: assert property (p_wr_taken) else $error("accepted write not stored");
    property p_wr_refused; reg_wr && !(wr_ok && mapped) |=> !nv_write; endproperty
    a_wr_refused: assert property (p_wr_refused) else $error("refused write stored");
    property p_reserved; nv_write && nv_addr != 8'hba |-> (nv_wdata & 8'h88) == 8'h00; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit stored");
    property p_clamp; bias_req_valid |=> bias_dac <= $past(bias_req); endproperty
    a_clamp: assert property (p_clamp) else $error("bias above request");
    property p_alarm;
        $rose(bias_max_alarm) |-> $past(bias_req_valid) && $past(bias_req) > bias_dac;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm without clamp");
    property p_los_range;
        nv_write && nv_addr == 8'hb8 |=>
            {1'b0, signal_loss_high_range, 1'b0, signal_loss_low_range} == $past(nv_wdata);
    endproperty
    a_los_range: assert property (p_los_range) else $error("loss ranges stale");
    property p_trip_range;
        nv_write && nv_addr == 8'hb9 |=>
            {1'b0, bias_trip_range, 1'b0, power_loop_range} == $past(nv_wdata);
    endproperty
    a_trip_range: assert property (p_trip_range) else $error("trip ranges stale");
    c_read: cover property (reg_rd && rd_ok);
    c_refused: cover property (reg_wr && !wr_ok);
    c_alarm: cover property ($rose(bias_max_alarm));
    c_alarm_clear: cover property ($fell(bias_max_alarm));
endmodule : qtrbc_bank_properties

// *** bench/qtrbc_host_model.sv ***
// Host side of the byte register port, standing in for the serial bus controller.
// Assumes the bench calls xfer and checks the answers itself.
`timescale 1ns/1ps
module qtrbc_host_model (
    // Clock and register port
    input wire logic clk_sys,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // ==========================================================================
    // Transfers
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        // Idle lines show the inverse, so a late sample cannot pass by luck.
        {reg_wr, reg_rd} <= 2'b00;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : xfer
endmodule : qtrbc_host_model

// *** bench/quick_trip_ranging_bias_clamp_tb.sv ***
// Bench for the ranging and bias ceiling bank: access rights, ranges, clamp and signal loss.
// Assumes the bank, host model and checker are compiled first.
`timescale 1ns/1ps
module quick_trip_ranging_bias_clamp_tb;
    logic clk_sys = 1'b0, nrst = 1'b0, reg_wr, reg_rd, reg_rvalid, nv_write, bias_max_alarm;
    logic password_level_one, password_level_two, table_rw_permit, table_read_permit, nv_load;
    logic loop_startup, search_done, bias_req_valid, rx_below_low, rx_above_high;
    logic los_low_alarm, los_high_alarm;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, nv_los_range, nv_trip_range, nv_bias_ceiling;
    logic [7:0] nv_addr, nv_wdata, bias_req, bias_dac;
    logic [2:0] signal_loss_high_range, signal_loss_low_range, bias_trip_range, power_loop_range;
    logic [7:0] q [$];
    logic [7:0] sh [8'hb8:8'hba] = '{default: 8'h00};
    logic [3:0] lv = 4'h0;
    int err_total = 0, n_compared = 0;
    qtrbc_bank qtrbc_bank_i (.*);
    qtrbc_host_model qtrbc_host_model_i (.*);
    // ==========================================================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic set_lv(input logic [3:0] v);
        @(posedge clk_sys);
        {table_read_permit, table_rw_permit, password_level_two, password_level_one} <= v;
        lv = v;
    endtask : set_lv
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if ((lv[1] || (lv[0] && lv[2])) && a inside {[8'hb8:8'hba]}) begin
            sh[a] = (a == 8'hba) ? d : (d & 8'h77);
        end
        qtrbc_host_model_i.xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        q.push_back((lv[1] || lv[0] && (lv[2] || lv[3])) && a inside {[8'hb8:8'hba]} ? sh[a] : 8'h00);
        qtrbc_host_model_i.xfer(1'b0, a, 8'h00);
    endtask : rd
    task automatic bias(input logic [7:0] r, input logic [7:0] e, input logic al);
        @(posedge clk_sys);
        bias_req_valid <= 1'b1;
        bias_req <= r;
        @(posedge clk_sys);
        bias_req_valid <= 1'b0;
        @(negedge clk_sys);
        chk(bias_dac, e);
        chk({7'h00, bias_max_alarm}, {7'h00, al});
    endtask : bias
    task automatic wrap_up;
        // A read that never answered leaves its note behind and must not pass.
        if (q.size() != 0) err_total++;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // ==========================================================================
    // Processes
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (reg_rvalid === 1'b1) begin
            chk(reg_rdata, q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end
    initial begin
        {password_level_one, password_level_two, table_rw_permit, table_read_permit} = '0;
        {nv_load, nv_los_range, nv_trip_range, nv_bias_ceiling, loop_startup, search_done} = '0;
        {bias_req_valid, bias_req, rx_below_low, rx_above_high} = '0;
        void'($urandom(32'h3cd1_5543));
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        set_lv(4'h2);
        for (int a = 0; a < 3; a++) rd(8'hb8 + 8'(a));
        // Every mix of rights gets a random write and a read back under the same rights.
        for (int i = 0; i < 16; i++) begin
            set_lv(i[3:0]);
            wr(8'hb8 + 8'(i % 3), 8'($urandom));
            rd(8'hb8 + 8'(i % 3));
        end
        set_lv(4'h2);
        wr(8'hbb, 8'h5a);
        rd(8'hbb);
        repeat (3) @(negedge clk_sys);
        chk({1'b0, signal_loss_high_range, 1'b0, signal_loss_low_range}, sh[8'hb8]);
        chk({1'b0, bias_trip_range, 1'b0, power_loop_range}, sh[8'hb9]);
        $display("test access done");
        @(posedge clk_sys);
        {nv_load, nv_los_range, nv_trip_range, nv_bias_ceiling} <= {1'b1, 24'hff_ff40};
        @(posedge clk_sys);
        nv_load <= 1'b0;
        sh = '{8'h77, 8'h77, 8'h40};
        for (int a = 0; a < 3; a++) rd(8'hb8 + 8'(a));
        $display("test store done");
        // Before any startup the loop is idle, so an over-ceiling request only clamps.
        bias(8'h50, 8'h40, 1'b0);
        @(posedge clk_sys) loop_startup <= 1'b1;
        @(posedge clk_sys) loop_startup <= 1'b0;
        bias(8'hff, 8'h40, 1'b0);
        @(posedge clk_sys) search_done <= 1'b1;
        @(posedge clk_sys) search_done <= 1'b0;
        bias(8'h40, 8'h40, 1'b0);
        bias(8'h41, 8'h40, 1'b1);
        // A restart clears the sticky alarm and mutes it again until the search ends.
        @(posedge clk_sys) loop_startup <= 1'b1;
        @(posedge clk_sys) loop_startup <= 1'b0;
        bias(8'h41, 8'h40, 1'b0);
        $display("test bias done");
        for (int s = 0; s < 3; s++) begin
            @(posedge clk_sys);
            {rx_below_low, rx_above_high} <= (s == 1) ? 2'b10 : 2'b01;
            repeat (8) @(negedge clk_sys);
            chk({6'h00, los_low_alarm, los_high_alarm}, {6'h00, s == 1, s == 2});
        end
        $display("test loss done");
        repeat (4) @(posedge clk_sys);
        wrap_up();
    end
endmodule : quick_trip_ranging_bias_clamp_tb
bind qtrbc_bank qtrbc_bank_properties qtrbc_bank_properties_i (.*);
